// File: verilog/eea_pkg.sv
package eea_pkg;
  // Word address and page geometry
  localparam int ADDR_W = 16;
  localparam int BYTE_BITS = 8;
  localparam int BYTE_MSB = BYTE_BITS - 1;
  localparam int PAGE_BYTES = 64;
  localparam int PAGE_AW = 6;
  localparam int IDX_W = PAGE_AW + 1;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;

  // Internal programming time
  localparam int T_WR_US = 5000;
  localparam int CLK_MHZ = 250;
  localparam int WR_CYCLES = T_WR_US * CLK_MHZ;

  // Slave address byte fields
  localparam int TYPE_HI = 7;
  localparam int TYPE_LO = 4;
  localparam int SEL_HI = 3;
  localparam int SEL_LO = 1;
  localparam int DIR_BIT = 0;

  // Bundle of inputs synchronised onto the link clock
  localparam int PIN_W = 7;
  localparam int P_SCL = 6;
  localparam int P_SDA = 5;
  localparam int P_WP = 4;
  localparam int P_SEL_HI = 3;
  localparam int P_SEL_LO = 1;
  localparam int P_ACK = 0;
  localparam logic [PIN_W-1:0] PIN_RV = 7'h60;

  // Bit level state of the link
  typedef enum {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} eea_state_e;
  // Meaning of the byte being received
  typedef enum {K_DEV, K_AHI, K_ALO, K_DATA} eea_kind_e;
endpackage : eea_pkg

// File: verilog/eea_sync.sv
`timescale 1ns/10ps
module eea_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RV = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // Two flop synchroniser, first stage read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RV;
      q <= RV;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : eea_sync

// File: verilog/eea_wrtimer.sv
`timescale 1ns/10ps
module eea_wrtimer #(
  parameter int CYCLES = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(1);

  logic [CW-1:0] cnt_q;

  // Down counter for one programming cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= LOAD;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - LAST;
    end
  end

  // One cycle end pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= (cnt_q == LAST) && !start;
    end
  end

  assign busy = (cnt_q != '0);
endmodule : eea_wrtimer

// File: verilog/eea_slave.sv
`timescale 1ns/10ps
module eea_slave #(
  parameter int WR_CYCLES = eea_pkg::WR_CYCLES,
  parameter logic [3:0] DEV_TYPE = 4'h5 // Arbitrary type code
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic LINK_CLK,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic WP,
  input wire logic DEVICE_SELECT_BIT0_PIN,
  input wire logic DEVICE_SELECT_BIT1_PIN,
  input wire logic DEVICE_SELECT_BIT2_PIN,
  output logic [eea_pkg::ADDR_W-1:0] MEM_RD_ADDR,
  input wire logic [eea_pkg::BYTE_MSB:0] MEM_RD_DATA,
  output logic MEM_WR_EN,
  output logic [eea_pkg::ADDR_W-1:0] MEM_WR_ADDR,
  output logic [eea_pkg::BYTE_MSB:0] MEM_WR_DATA,
  output logic PROG_BUSY
);
  import eea_pkg::*;

  localparam logic [PAGE_AW-1:0] PAGE_ONE = PAGE_AW'(1);
  localparam logic [ADDR_W-1:0] ADDR_ONE = ADDR_W'(1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [IDX_W-1:0] IDX_END = IDX_W'(PAGE_BYTES);
  localparam logic [IDX_W-1:0] IDX_ONE = IDX_W'(1);

  // Link domain
  logic lrst_n;
  logic [PIN_W-1:0] pin_s;
  logic scl_s, sda_s, wp_s, ack_s;
  logic [SEL_HI-SEL_LO:0] sel_s;
  logic scl_q, sda_q;
  logic busy_l;
  logic start_ev, stop_ev, rise, fall;
  eea_state_e st_q;
  eea_kind_e kind_q;
  logic [CNT_W-1:0] cnt_q;
  logic [BYTE_MSB:0] sh_q;
  logic [BYTE_MSB:0] hi_q;
  logic [ADDR_W-1:0] ptr_q;
  logic sda_oe_q, rd_q, mack_q, wr_act_q, req_t_q;
  logic [PAGE_BYTES-1:0] valid_q;
  logic [BYTE_MSB:0] pbuf [PAGE_BYTES];
  logic byte_fin, dev_hit, rx_ack, load;

  // System domain
  logic req_s, req_seen_q, prog_ev, tmr_done, ack_t_q;
  logic [IDX_W-1:0] idx_q;
  logic wr_en_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [BYTE_MSB:0] wr_data_q;

  // Type code and select pins against the address byte
  function automatic logic addr_match(
    input logic [BYTE_MSB:0] b,
    input logic [SEL_HI-SEL_LO:0] sel,
    input logic [3:0] dtype
  );
    addr_match = (b[TYPE_HI:TYPE_LO] == dtype) &&
                 (b[SEL_HI:SEL_LO] == sel);
  endfunction : addr_match

  // Byte meaning that follows an acknowledged byte of a write
  function automatic eea_kind_e next_kind(input eea_kind_e k);
    case (k)
      K_DEV: next_kind = K_AHI;
      K_AHI: next_kind = K_ALO;
      default: next_kind = K_DATA;
    endcase
  endfunction : next_kind

  // Link reset: asserted at once, released on the link clock
  eea_sync #(
    .W(1),
    .RV(1'b0)
  ) u_lrst (
    .clk(LINK_CLK),
    .rst_n(RESETN),
    .d(1'b1),
    .q(lrst_n)
  );

  // Pins and the done toggle brought onto the link clock
  eea_sync #(
    .W(PIN_W),
    .RV(PIN_RV)
  ) u_pins (
    .clk(LINK_CLK),
    .rst_n(lrst_n),
    .d({SCL, SDA_IN, WP, DEVICE_SELECT_BIT2_PIN, DEVICE_SELECT_BIT1_PIN,
        DEVICE_SELECT_BIT0_PIN, ack_t_q}),
    .q(pin_s)
  );

  // Unpack the synchronised bundle
  assign scl_s = pin_s[P_SCL];
  assign sda_s = pin_s[P_SDA];
  assign wp_s = pin_s[P_WP];
  assign sel_s = pin_s[P_SEL_HI:P_SEL_LO];
  assign ack_s = pin_s[P_ACK];

  // Previous line levels for edge and condition detection
  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // Bus events, all masked while a programming cycle runs
  assign busy_l = req_t_q ^ ack_s;
  assign start_ev = !busy_l && scl_s && scl_q && sda_q && !sda_s;
  assign stop_ev = !busy_l && scl_s && scl_q && !sda_q && sda_s;
  assign rise = !busy_l && scl_s && !scl_q;
  assign fall = !busy_l && !scl_s && scl_q;

  // Byte decode at the falling edge that opens the ninth clock
  assign byte_fin = fall && (st_q == ST_RX) && (cnt_q == CNT_FULL);
  assign dev_hit = addr_match(sh_q, sel_s, DEV_TYPE);
  assign rx_ack = (kind_q != K_DEV) || dev_hit;
  assign load = fall && (((st_q == ST_RX_ACK) && rd_q) ||
                         ((st_q == ST_TX_ACK) && mack_q));

  // Bit sequencer: receive, acknowledge, transmit
  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      st_q <= ST_IDLE;
      kind_q <= K_DEV;
      cnt_q <= '0;
      sh_q <= '0;
      sda_oe_q <= 1'b0;
      rd_q <= 1'b0;
      mack_q <= 1'b0;
    end else if (start_ev) begin
      st_q <= ST_RX;
      kind_q <= K_DEV;
      cnt_q <= '0;
      sda_oe_q <= 1'b0;
    end else if (stop_ev) begin
      st_q <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (st_q)
        ST_RX: begin
          if (rise) begin
            sh_q <= {sh_q[BYTE_MSB-1:0], sda_s};
            cnt_q <= cnt_q + CNT_ONE;
          end else if (byte_fin) begin
            if (rx_ack) begin
              st_q <= ST_RX_ACK;
              sda_oe_q <= 1'b1;
              if (kind_q == K_DEV) begin
                rd_q <= sh_q[DIR_BIT];
              end
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_RX_ACK: begin
          if (fall) begin
            cnt_q <= '0;
            if (rd_q) begin
              st_q <= ST_TX;
              sh_q <= MEM_RD_DATA;
              sda_oe_q <= !MEM_RD_DATA[BYTE_MSB];
            end else begin
              st_q <= ST_RX;
              sda_oe_q <= 1'b0;
              kind_q <= next_kind(kind_q);
            end
          end
        end
        ST_TX: begin
          if (rise) begin
            cnt_q <= cnt_q + CNT_ONE;
          end else if (fall) begin
            if (cnt_q == CNT_FULL) begin
              st_q <= ST_TX_ACK;
              sda_oe_q <= 1'b0;
            end else begin
              sh_q <= {sh_q[BYTE_MSB-1:0], 1'b0};
              sda_oe_q <= !sh_q[BYTE_MSB-1];
            end
          end
        end
        ST_TX_ACK: begin
          if (rise) begin
            mack_q <= !sda_s;
          end else if (fall) begin
            cnt_q <= '0;
            if (mack_q) begin
              st_q <= ST_TX;
              sh_q <= MEM_RD_DATA;
              sda_oe_q <= !MEM_RD_DATA[BYTE_MSB];
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Word address pointer
  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      ptr_q <= '0;
      hi_q <= '0;
    end else if (byte_fin && (kind_q == K_AHI)) begin
      hi_q <= sh_q;
    end else if (byte_fin && (kind_q == K_ALO)) begin
      ptr_q <= {hi_q, sh_q};
    end else if (byte_fin && (kind_q == K_DATA)) begin
      ptr_q[PAGE_AW-1:0] <= ptr_q[PAGE_AW-1:0] + PAGE_ONE;
    end else if (load) begin
      ptr_q <= ptr_q + ADDR_ONE;
    end
  end

  // Write transaction tracking and page valid mask
  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      wr_act_q <= 1'b0;
      valid_q <= '0;
    end else if (start_ev || stop_ev) begin
      wr_act_q <= 1'b0;
    end else if (byte_fin && (kind_q == K_DEV) && dev_hit &&
                 !sh_q[DIR_BIT]) begin
      wr_act_q <= 1'b1;
      valid_q <= '0;
    end else if (byte_fin && (kind_q == K_DATA)) begin
      valid_q[ptr_q[PAGE_AW-1:0]] <= 1'b1;
    end
  end

  // Page buffer; later bytes overwrite earlier ones on wrap
  always_ff @(posedge LINK_CLK) begin
    if (byte_fin && (kind_q == K_DATA)) begin
      pbuf[ptr_q[PAGE_AW-1:0]] <= sh_q;
    end
  end

  // Programming request toggle, raised only by a stop
  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      req_t_q <= 1'b0;
    end else if (stop_ev && wr_act_q && (valid_q != '0) && !wp_s) begin
      req_t_q <= ~req_t_q;
    end
  end

  // Open drain data pin and read address
  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_oe_q;
  assign MEM_RD_ADDR = ptr_q;

  // Request toggle onto the system clock
  eea_sync #(
    .W(1),
    .RV(1'b0)
  ) u_req (
    .clk(CLK),
    .rst_n(RESETN),
    .d(req_t_q),
    .q(req_s)
  );

  // Request edge
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      req_seen_q <= 1'b0;
    end else begin
      req_seen_q <= req_s;
    end
  end

  assign prog_ev = req_s ^ req_seen_q;

  // Programming cycle length
  eea_wrtimer #(
    .CYCLES(WR_CYCLES)
  ) u_tmr (
    .clk(CLK),
    .rst_n(RESETN),
    .start(prog_ev),
    .busy(PROG_BUSY),
    .done(tmr_done)
  );

  // Walk the page once, writing only received bytes
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      idx_q <= IDX_END;
    end else if (prog_ev) begin
      idx_q <= '0;
    end else if (idx_q != IDX_END) begin
      idx_q <= idx_q + IDX_ONE;
    end
  end

  // Memory write port; page buffer is stable while busy
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_en_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end else begin
      wr_en_q <= (idx_q != IDX_END) &&
                 valid_q[idx_q[PAGE_AW-1:0]];
      wr_addr_q <= {ptr_q[ADDR_W-1:PAGE_AW], idx_q[PAGE_AW-1:0]};
      wr_data_q <= pbuf[idx_q[PAGE_AW-1:0]];
    end
  end

  assign MEM_WR_EN = wr_en_q;
  assign MEM_WR_ADDR = wr_addr_q;
  assign MEM_WR_DATA = wr_data_q;

  // Done toggle back to the link, ending the busy window
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack_t_q <= 1'b0;
    end else if (tmr_done) begin
      ack_t_q <= ~ack_t_q;
    end
  end
endmodule : eea_slave

// File: sim/eea_slave_checker.sv
`timescale 1ns/10ps
module eea_slave_checker #(
  parameter int WR_CYCLES = eea_pkg::WR_CYCLES
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic LINK_CLK,
  input wire logic SCL,
  input wire logic SDA_OE,
  input wire logic WP,
  input wire logic [eea_pkg::ADDR_W-1:0] MEM_RD_ADDR,
  input wire logic MEM_WR_EN,
  input wire logic [eea_pkg::ADDR_W-1:0] MEM_WR_ADDR,
  input wire logic PROG_BUSY
);
  import eea_pkg::*;
  int cnt_q;
  logic seen_q;
  logic [ADDR_W-1:0] last_q;
  // Cycles spent in the current busy stretch
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) cnt_q <= 0;
    else cnt_q <= PROG_BUSY ? cnt_q + 1 : 0;
  end
  // Earlier write pulse seen in this stretch
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) seen_q <= 1'b0;
    else seen_q <= PROG_BUSY && (seen_q || MEM_WR_EN);
  end
  // Address of that pulse
  always_ff @(posedge CLK) begin
    if (MEM_WR_EN) last_q <= MEM_WR_ADDR;
  end
  a_wr_in_busy: assert property (
    @(posedge CLK) disable iff (!RESETN) MEM_WR_EN |-> PROG_BUSY)
    else $error("write pulse while idle");
  a_wp_no_write: assert property (
    @(posedge CLK) disable iff (!RESETN) MEM_WR_EN |-> !WP)
    else $error("write pulse while protected");
  a_busy_no_ack: assert property (
    @(posedge CLK) disable iff (!RESETN) PROG_BUSY |-> !SDA_OE)
    else $error("data line pulled while busy");
  a_page_stays: assert property (
    @(posedge CLK) disable iff (!RESETN) MEM_WR_EN && seen_q |->
    MEM_WR_ADDR[15:6] == last_q[15:6] && MEM_WR_ADDR[5:0] > last_q[5:0])
    else $error("write left the page or went down");
  a_busy_length: assert property (
    @(posedge CLK) disable iff (!RESETN) $fell(PROG_BUSY) |->
    cnt_q inside {[WR_CYCLES - 2:WR_CYCLES + 2]})
    else $error("busy stretch of wrong length");
  a_wr_early: assert property (
    @(posedge CLK) disable iff (!RESETN) MEM_WR_EN |-> cnt_q <= 70)
    else $error("write pulse too late in busy");
  a_ptr_frozen: assert property (
    @(posedge CLK) disable iff (!RESETN)
    PROG_BUSY && $past(PROG_BUSY, 4) |-> $stable(MEM_RD_ADDR))
    else $error("pointer moved while busy");
  a_oe_scl_low: assert property (
    @(posedge LINK_CLK) disable iff (!RESETN) $changed(SDA_OE) |-> !SCL)
    else $error("data line changed with clock high");
endmodule : eea_slave_checker

bind eea_slave eea_slave_checker #(.WR_CYCLES(WR_CYCLES))
  i_eea_slave_checker (.CLK, .RESETN, .LINK_CLK, .SCL, .SDA_OE, .WP,
  .MEM_RD_ADDR, .MEM_WR_EN, .MEM_WR_ADDR, .PROG_BUSY);

// File: sim/eea_bus_master.sv
`timescale 1ns/10ps
module eea_bus_master #(
  parameter int HALF = 40
) (
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  // Both lines idle high between frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Start or repeated start: data falls with clock high
  task automatic start();
    #(HALF / 4) sda_drv = 1'b1;
    #HALF scl = 1'b1;
    #HALF sda_drv = 1'b0;
    #HALF scl = 1'b0;
  endtask : start
  // Stop: data rises with clock high, clock then stands high
  task automatic stop();
    #(HALF / 4) sda_drv = 1'b0;
    #HALF scl = 1'b1;
    #HALF sda_drv = 1'b1;
    #HALF;
  endtask : stop
  // One clock pulse, data set while low, sampled at end of high
  task automatic clock_bit(input logic b, output logic s);
    #(HALF / 4) sda_drv = b;
    #HALF scl = 1'b1;
    #HALF s = sda_line;
    scl = 1'b0;
  endtask : clock_bit
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
    clock_bit(1'b1, s);
    ack = ~s;
  endtask : put_byte
  task automatic get_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, s);
      b[i] = s;
    end
    clock_bit(~ack, s);
  endtask : get_byte
endmodule : eea_bus_master

// File: sim/eea_slave_bench.sv
`timescale 1ns/10ps
module eea_slave_bench;
  localparam logic [3:0] DTYPE = 4'h9; // Arbitrary type code
  localparam logic [7:0] WRA = 8'h9A;
  localparam logic [7:0] RDA = 8'h9B;
  localparam logic [7:0] BAD [2] = '{8'h9C, 8'h8A};
  typedef struct {
    logic [15:0] addr;
    logic [7:0] data;
    logic [15:0] ptr;
  } eea_row_s;
  eea_row_s rows [3] = '{'{16'h0010, 8'hA5, 16'h0011},
    '{16'h1234, 8'h5A, 16'h1235}, '{16'hABFF, 8'h3C, 16'hABC0}};
  logic clk, link_clk, resetn, wp, scl, sda_drv, sda_oe, sda_out, wr_en;
  logic busy;
  logic [15:0] rd_addr, wr_addr;
  logic [7:0] wr_data;
  logic [7:0] mem [0:65535];
  logic [7:0] shadow [0:65535];
  // Open drain line: pulled low when the master drives low or the device drives its low level
  wire logic sda_line = sda_drv & ~(sda_oe & ~sda_out);
  int fails, samples_checked, wr_count, n, w0;
  eea_slave #(.WR_CYCLES(1000), .DEV_TYPE(DTYPE)) i_eea_slave (
    .CLK(clk), .RESETN(resetn), .LINK_CLK(link_clk), .SCL(scl),
    .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .WP(wp),
    .DEVICE_SELECT_BIT0_PIN(1'b1), .DEVICE_SELECT_BIT1_PIN(1'b0),
    .DEVICE_SELECT_BIT2_PIN(1'b1), .MEM_RD_ADDR(rd_addr),
    .MEM_RD_DATA(mem[rd_addr]), .MEM_WR_EN(wr_en), .MEM_WR_ADDR(wr_addr),
    .MEM_WR_DATA(wr_data), .PROG_BUSY(busy));
  eea_bus_master i_eea_bus_master (.scl(scl), .sda_drv(sda_drv),
    .sda_line(sda_line));
  // Clocks, link clock unrelated in phase
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  // Memory array behind the write port
  always @(posedge clk) begin
    if (wr_en === 1'b1) begin
      mem[wr_addr] <= wr_data;
      wr_count++;
    end
  end
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tx(input logic [7:0] b, input logic ack);
    logic a;
    i_eea_bus_master.put_byte(b, a);
    check("ack", 16'(a), 16'(ack));
  endtask : tx
  task automatic set_ptr(input logic [15:0] a);
    i_eea_bus_master.start();
    tx(WRA, 1'b1);
    tx(a[15:8], 1'b1);
    tx(a[7:0], 1'b1);
  endtask : set_ptr
  task automatic rd(input logic [15:0] a, input int cnt);
    logic [7:0] b;
    i_eea_bus_master.start();
    tx(RDA, 1'b1);
    for (int k = 0; k < cnt; k++) begin
      i_eea_bus_master.get_byte(k < cnt - 1, b);
      check("read", 16'(b), 16'(shadow[a + 16'(k)]));
    end
    i_eea_bus_master.stop();
  endtask : rd
  // Address polls until the device answers again
  task automatic poll();
    logic a;
    n = 0;
    do begin
      i_eea_bus_master.start();
      i_eea_bus_master.put_byte(WRA, a);
      i_eea_bus_master.stop();
      n++;
    end while (a !== 1'b1 && n < 40);
    check("poll ack", 16'(a), 16'h0001);
  endtask : poll
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial begin
    #300us;
    fails++;
    summarize();
  end
  initial begin
    resetn = 1'b0;
    wp = 1'b0;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
      shadow[i] = mem[i];
    end
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (8) @(posedge clk);
    // Byte writes, busy polling, random read back
    foreach (rows[r]) begin
      w0 = wr_count;
      set_ptr(rows[r].addr);
      tx(rows[r].data, 1'b1);
      i_eea_bus_master.stop();
      shadow[rows[r].addr] = rows[r].data;
      poll();
      check("busy polls", 16'(n > 1), 16'h0001);
      check("writes", 16'(wr_count - w0), 16'h0001);
      check("pointer", rd_addr, rows[r].ptr);
      set_ptr(rows[r].addr);
      rd(rows[r].addr, 1);
    end
    // Page write running past the page end, read across it
    w0 = wr_count;
    set_ptr(16'h017E);
    for (int k = 0; k < 66; k++) begin
      tx(8'(k), 1'b1);
      shadow[{10'h005, 6'(62 + k)}] = 8'(k);
    end
    i_eea_bus_master.stop();
    poll();
    check("page writes", 16'(wr_count - w0), 16'h0040);
    check("page pointer", rd_addr, 16'h0140);
    set_ptr(16'h017E);
    rd(16'h017E, 4);
    // Protected write: all acknowledged, nothing programmed
    @(posedge clk);
    #1 wp = 1'b1;
    w0 = wr_count;
    set_ptr(16'h0300);
    tx(8'h77, 1'b1);
    i_eea_bus_master.stop();
    poll();
    check("protected polls", 16'(n), 16'h0001);
    check("protected writes", 16'(wr_count - w0), 16'h0000);
    @(posedge clk);
    #1 wp = 1'b0;
    // Foreign type or select, ignored until the next start
    foreach (BAD[i]) begin
      i_eea_bus_master.start();
      tx(BAD[i], 1'b0);
      tx(WRA, 1'b0);
      i_eea_bus_master.stop();
    end
    // Sequential read over the top of memory, then current address
    set_ptr(16'hFFFE);
    rd(16'hFFFE, 3);
    check("released", 16'(sda_oe), 16'h0000);
    rd(16'h0001, 1);
    // Reset in mid transfer
    i_eea_bus_master.start();
    tx(WRA, 1'b1);
    @(posedge clk);
    #1 resetn = 1'b0;
    repeat (4) @(posedge clk);
    check("reset oe", 16'(sda_oe), 16'h0000);
    check("reset ptr", rd_addr, 16'h0000);
    check("reset busy", 16'({busy, wr_en}), 16'h0000);
    i_eea_bus_master.stop();
    @(posedge clk);
    #1 resetn = 1'b1;
    repeat (8) @(posedge clk);
    rd(16'h0000, 1);
    summarize();
  end
endmodule : eea_slave_bench
